/* core/mqp_memop_queue_pipe.sv */
// mqp_memop_queue_pipe: memop_reorder_queue and three-stage cache probe
// assumes dispatch, address_generator pair and data cache on mclk
`timescale 1ns/10ps
`default_nettype none

module mqp_memop_queue_pipe (
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              reset_n,
  input  wire logic                              clk_en,
  // dispatch
  input  wire logic                              disp_valid,
  input  wire mqp_pkg::mqp_macro_t               disp_op,
  output var  logic                              disp_ready_q,
  output var  logic [mqp_pkg::IDXW-1:0]          disp_idx_q,
  // address generators
  input  wire mqp_pkg::mqp_agu_t [1:0]           agu_in,
  output var  logic [mqp_pkg::QDEPTH-1:0]        agu_ok_q,
  // cache probe stages and data cache
  output var  mqp_pkg::mqp_probe_t [1:0]         probe_a_q,
  output var  mqp_pkg::mqp_probe_t [1:0]         probe_b_q,
  input  wire logic [1:0][mqp_pkg::DATAW-1:0]    dc_rdata,
  // load results and execute start
  output var  mqp_pkg::mqp_result_t [1:0]        result_q,
  output var  logic [1:0]                        ieu_start_q
);

  localparam int N = mqp_pkg::QDEPTH;
  localparam int W = mqp_pkg::IDXW;

  function automatic logic [W-1:0] nxt(input logic [W-1:0] p);
    return (p == mqp_pkg::IDX_LAST) ? mqp_pkg::IDX_ZERO : W'(p + mqp_pkg::IDX_ONE);
  endfunction

  function automatic logic [W-1:0] prv(input logic [W-1:0] p);
    return (p == mqp_pkg::IDX_ZERO) ? mqp_pkg::IDX_LAST : W'(p - mqp_pkg::IDX_ONE);
  endfunction

  // queue entries
  logic                   val_q   [N];
  mqp_pkg::mqp_kind_t     kind_q  [N];
  mqp_pkg::mqp_width_t    width_q [N];
  logic                   lexe_q  [N];
  logic                   twin_q  [N];
  logic                   av_q    [N];
  logic [mqp_pkg::ADDRW-1:0] addr_q [N];
  logic                   blk_q   [N];
  logic [W-1:0]           dep_q   [N];
  logic [W-1:0]           head_q;
  logic [W-1:0]           tail_q;
  logic [4:0]             count_q;

  // address writes with same-cycle bypass
  logic                   wr_hit  [N];
  logic [mqp_pkg::ADDRW-1:0] wr_addr [N];
  logic                   rdy     [N];
  logic [mqp_pkg::ADDRW-1:0] cur_addr [N];
  logic                   done_hit [N];

  for (genvar i = 0; i < N; i++) begin : g_ent
    wire [W-1:0] me   = W'(i);
    wire [W-1:0] src  = twin_q[i] ? prv(me) : me;
    wire         h0   = agu_in[0].valid && agu_in[0].idx == src;
    wire         h1   = agu_in[1].valid && agu_in[1].idx == src;
    assign wr_hit[i]   = val_q[i] && !av_q[i] && !blk_q[i] && (h0 || h1);
    assign wr_addr[i]  = h0 ? agu_in[0].addr : agu_in[1].addr;
    assign rdy[i]      = val_q[i] && (av_q[i] || wr_hit[i]);
    assign cur_addr[i] = av_q[i] ? addr_q[i] : wr_addr[i];
    // a load leaving stage three releases its dependants
    assign done_hit[i] = (probe_b_q[0].valid && probe_b_q[0].kind == mqp_pkg::MQP_LOAD
                          && probe_b_q[0].idx == dep_q[i])
                      || (probe_b_q[1].valid && probe_b_q[1].kind == mqp_pkg::MQP_LOAD
                          && probe_b_q[1].idx == dep_q[i]);
  end

  // in-order scan of head and next entry
  wire [W-1:0] e0      = head_q;
  wire [W-1:0] e1      = nxt(head_q);
  wire         st_pair = kind_q[e0] == mqp_pkg::MQP_STORE
                      && kind_q[e1] == mqp_pkg::MQP_STORE;
  wire         wide    = width_q[e0] == mqp_pkg::MQP_W64
                      || width_q[e1] == mqp_pkg::MQP_W64;
  wire         pair_ok = !(st_pair && wide);
  wire         go0     = rdy[e0];
  wire         go1     = go0 && rdy[e1] && pair_ok;
  wire [1:0]   n_scan  = {1'b0, go0} + {1'b0, go1};

  // dispatch split into primitive entries
  wire         take    = disp_valid && disp_ready_q;
  wire         both    = disp_op.has_load && disp_op.has_store;
  wire [1:0]   n_alloc = take ? ({1'b0, disp_op.has_load} + {1'b0, disp_op.has_store})
                              : 2'b00;
  wire [W-1:0] t1      = nxt(tail_q);
  wire         dep_now = disp_op.dep_valid
                      && !((probe_b_q[0].valid && probe_b_q[0].kind == mqp_pkg::MQP_LOAD
                            && probe_b_q[0].idx == disp_op.dep_idx)
                        || (probe_b_q[1].valid && probe_b_q[1].kind == mqp_pkg::MQP_LOAD
                            && probe_b_q[1].idx == disp_op.dep_idx));
  wire [4:0]   count_d = 5'(count_q + {3'b000, n_alloc} - {3'b000, n_scan});
  wire [W-1:0] head_d  = go1 ? nxt(e1) : (go0 ? e1 : e0);
  wire [W-1:0] tail_d  = (n_alloc == 2'b10) ? nxt(t1) : ((n_alloc == 2'b01) ? t1 : tail_q);

  // stage-one probe slots
  mqp_pkg::mqp_probe_t [1:0] scan_s;
  assign scan_s[0] = '{valid: go0, kind: kind_q[e0], width: width_q[e0],
                       load_exec: lexe_q[e0], idx: e0, addr: cur_addr[e0]};
  assign scan_s[1] = '{valid: go1, kind: kind_q[e1], width: width_q[e1],
                       load_exec: lexe_q[e1], idx: e1, addr: cur_addr[e1]};

  // forwarded load data from the second half of the access
  mqp_pkg::mqp_result_t [1:0] res_d;
  for (genvar s = 0; s < mqp_pkg::SCAN_MAX; s++) begin : g_res
    assign res_d[s] = '{valid: probe_b_q[s].valid && probe_b_q[s].kind == mqp_pkg::MQP_LOAD,
                        load_exec: probe_b_q[s].load_exec,
                        idx: probe_b_q[s].idx, data: dc_rdata[s]};
  end

  // queue pointers and flow control
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      head_q       <= mqp_pkg::IDX_ZERO;
      tail_q       <= mqp_pkg::IDX_ZERO;
      count_q      <= mqp_pkg::CNT_ZERO;
      disp_ready_q <= 1'b0;
    end else if (clk_en) begin
      head_q       <= head_d;
      tail_q       <= tail_d;
      count_q      <= count_d;
      disp_ready_q <= count_d <= mqp_pkg::CNT_SPACE;
    end
  end

  assign disp_idx_q = tail_q;

  // entry state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N; i++) begin
        val_q[i]   <= 1'b0;
        kind_q[i]  <= mqp_pkg::MQP_LOAD;
        width_q[i] <= mqp_pkg::MQP_W32;
        lexe_q[i]  <= 1'b0;
        twin_q[i]  <= 1'b0;
        av_q[i]    <= 1'b0;
        addr_q[i]  <= '0;
        blk_q[i]   <= 1'b0;
        dep_q[i]   <= mqp_pkg::IDX_ZERO;
      end
    end else if (clk_en) begin
      for (int i = 0; i < N; i++) begin
        if (wr_hit[i]) begin
          av_q[i]   <= 1'b1;
          addr_q[i] <= wr_addr[i];
        end
        if (blk_q[i] && done_hit[i])
          blk_q[i] <= 1'b0;
        if ((go0 && W'(i) == e0) || (go1 && W'(i) == e1))
          val_q[i] <= 1'b0;
        if (take && (W'(i) == tail_q || (both && W'(i) == t1))) begin
          val_q[i]   <= 1'b1;
          kind_q[i]  <= (disp_op.has_load && W'(i) == tail_q)
                        ? mqp_pkg::MQP_LOAD : mqp_pkg::MQP_STORE;
          width_q[i] <= disp_op.width;
          lexe_q[i]  <= disp_op.load_exec && W'(i) == tail_q;
          twin_q[i]  <= both && W'(i) == t1;
          av_q[i]    <= 1'b0;
          blk_q[i]   <= dep_now;
          dep_q[i]   <= disp_op.dep_idx;
        end
      end
    end
  end

  // probe pipeline, results and address-generator permission
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      probe_a_q   <= '0;
      probe_b_q   <= '0;
      result_q    <= '0;
      ieu_start_q <= 2'b00;
      agu_ok_q    <= '0;
    end else if (clk_en) begin
      probe_a_q   <= scan_s;
      probe_b_q   <= probe_a_q;
      result_q    <= res_d;
      ieu_start_q <= {res_d[1].valid && res_d[1].load_exec,
                      res_d[0].valid && res_d[0].load_exec};
      for (int i = 0; i < N; i++)
        agu_ok_q[i] <= val_q[i] && !av_q[i] && !twin_q[i] && !wr_hit[i]
                       && !(blk_q[i] && !done_hit[i]);
    end
  end

endmodule

`default_nettype wire

/* core/mqp_pkg.sv */
// mqp_pkg: constants and carrier types of the memory operation queue pipe
// assumes one core clock; shared by the design and its bench
package mqp_pkg;

  localparam int          QDEPTH    = 12;
  localparam int          IDXW      = 4;
  localparam int          ADDRW     = 32;
  localparam int          DATAW     = 64;
  localparam int          SCAN_MAX  = 2;
  localparam int          FREE_MIN  = 2;
  localparam logic [3:0]  IDX_ZERO  = 4'h0;
  localparam logic [3:0]  IDX_LAST  = 4'hB;
  localparam logic [3:0]  IDX_ONE   = 4'h1;
  localparam logic [4:0]  CNT_ZERO  = 5'h00;
  localparam logic [4:0]  CNT_SPACE = 5'h0A;

  typedef enum logic {MQP_LOAD, MQP_STORE} mqp_kind_t;
  typedef enum logic {MQP_W32, MQP_W64}    mqp_width_t;

  // macro operation from dispatch, split by the queue pipe into primitive operations
  typedef struct packed {
    logic            has_load;
    logic            has_store;
    mqp_width_t      width;
    logic            load_exec;
    logic            dep_valid;
    logic [IDXW-1:0] dep_idx;
  } mqp_macro_t;

  // address from one address generator
  typedef struct packed {
    logic             valid;
    logic [IDXW-1:0]  idx;
    logic [ADDRW-1:0] addr;
  } mqp_agu_t;

  // one slot of the cache probe pipeline
  typedef struct packed {
    logic             valid;
    mqp_kind_t        kind;
    mqp_width_t       width;
    logic             load_exec;
    logic [IDXW-1:0]  idx;
    logic [ADDRW-1:0] addr;
  } mqp_probe_t;

  // forwarded load data
  typedef struct packed {
    logic             valid;
    logic             load_exec;
    logic [IDXW-1:0]  idx;
    logic [DATAW-1:0] data;
  } mqp_result_t;

endpackage

/* verif/mqp_dcache_model.sv */
// mqp_dcache_model: data cache answering stage b probes
// assumes load data is read in the same cycle as stage b
`timescale 1ns/10ps
`default_nettype none
module mqp_dcache_model (
  // stage b probes
  input  wire mqp_pkg::mqp_probe_t [1:0]      probe_b_q,
  // load data
  output var  logic [1:0][mqp_pkg::DATAW-1:0] dc_rdata
);
  // hit data is address and its inverse; idle slots show noise
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      dc_rdata[s] = probe_b_q[s].valid ? {probe_b_q[s].addr, ~probe_b_q[s].addr}
                                       : {2{probe_b_q[s].addr ^ 32'hA5A5A5A5}};
    end
  end
endmodule
`default_nettype wire

/* verif/mqp_memop_queue_pipe_tb.sv */
// mqp_memop_queue_pipe_tb: directed bench for the queue pipe
// assumes the cache model answers {addr, ~addr}
`timescale 1ns/10ps
`default_nettype none
module mqp_memop_queue_pipe_tb;
  logic                              mclk = 1'b0;
  logic                              reset_n = 1'b0;
  logic                              disp_valid = 1'b0;
  mqp_pkg::mqp_macro_t               disp_op = '0;
  mqp_pkg::mqp_agu_t [1:0]           agu_in = '0;
  logic                              disp_ready_q;
  logic [3:0]                        disp_idx_q;
  logic [11:0]                       agu_ok_q;
  mqp_pkg::mqp_probe_t [1:0]         probe_a_q;
  mqp_pkg::mqp_probe_t [1:0]         probe_b_q;
  logic [1:0][63:0]                  dc_rdata;
  mqp_pkg::mqp_result_t [1:0]        result_q;
  logic [1:0]                        ieu_start_q;
  int                                errors = 0;
  int                                tests_run = 0;
  always #4 mclk = ~mclk;
  mqp_memop_queue_pipe i_dut (.mclk, .reset_n, .clk_en(1'b1), .disp_valid,
    .disp_op, .disp_ready_q, .disp_idx_q, .agu_in, .agu_ok_q, .probe_a_q,
    .probe_b_q, .dc_rdata, .result_q, .ieu_start_q);
  mqp_dcache_model i_dc (.probe_b_q, .dc_rdata);
  task automatic summarize();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 64) begin
      errors++;
      summarize();
    end else @(negedge mclk);
  endtask
  function automatic logic [3:0] nx(logic [3:0] i);
    return (i == 4'hB) ? 4'h0 : i + 4'h1;
  endfunction
  task automatic disp(logic ld, logic st);
    int n = 0;
    while (disp_ready_q !== 1'b1) guard(n);
    disp_op = {ld, st, mqp_pkg::MQP_W64, 1'b1, 5'h00};
    disp_valid = 1'b1;
    @(negedge mclk);
    disp_valid = 1'b0;
    @(negedge mclk);
  endtask
  task automatic addr(int k, logic [3:0] idx, logic [31:0] a);
    int n = 0;
    while (agu_ok_q[idx] !== 1'b1) guard(n);
    agu_in[k] = {1'b1, idx, a};
    @(negedge mclk);
    agu_in[k] = '0;
  endtask
  task automatic t_load();
    logic [3:0] i = disp_idx_q;
    disp(1'b1, 1'b0);
    addr(0, i, 32'h12345678);
    chk("stage a addr", probe_a_q[0].addr, 32'h12345678);
    chk("stage a valid", probe_a_q[0].valid, 1'b1);
    @(negedge mclk);
    chk("stage b idx", probe_b_q[0].idx, i);
    @(negedge mclk);
    chk("load data", result_q[0].data, {32'h12345678, ~32'h12345678});
    chk("exec start", ieu_start_q, 2'h1);
    $display("test load done");
  endtask
  task automatic t_order();
    logic [3:0] i = disp_idx_q;
    disp(1'b1, 1'b0);
    disp(1'b1, 1'b0);
    addr(1, nx(i), 32'h0000BEEF);
    chk("younger held", probe_a_q[0].valid, 1'b0);
    addr(0, i, 32'h0000CAFE);
    chk("pair scanned", {probe_a_q[0].valid, probe_a_q[1].valid}, 2'h3);
    chk("older slot", probe_a_q[0].idx, i);
    $display("test order done");
  endtask
  task automatic t_full();
    logic [3:0] i = disp_idx_q;
    int n = 0;
    while (disp_ready_q === 1'b1 && n < 16) begin
      disp_op = {1'b1, 1'b0, mqp_pkg::MQP_W32, 1'b0, 5'h00};
      disp_valid = 1'b1;
      @(negedge mclk);
      n++;
    end
    disp_valid = 1'b0;
    chk("entries taken", n, 11);
    for (int k = 0; k < n; k++) begin
      addr(k % 2, i, 32'h100 + k);
      i = nx(i);
    end
    @(negedge mclk);
    chk("ready again", disp_ready_q, 1'b1);
    $display("test full done");
  endtask
  task automatic t_pair();
    logic [3:0] i = disp_idx_q;
    disp(1'b1, 1'b1);
    addr(0, i, 32'h00004000);
    chk("store twin", probe_a_q[1].kind, mqp_pkg::MQP_STORE);
    chk("store idx", probe_a_q[1].idx, nx(i));
    $display("test pair done");
  endtask
  task automatic t_dep();
    logic [3:0] i = disp_idx_q;
    disp(1'b1, 1'b0);
    disp_op = {1'b1, 1'b0, mqp_pkg::MQP_W64, 1'b0, 1'b1, i};
    disp_valid = 1'b1;
    @(negedge mclk);
    disp_valid = 1'b0;
    repeat (2) @(negedge mclk);
    chk("blocked entry", agu_ok_q[nx(i)], 1'b0);
    addr(0, i, 32'h00002000);
    @(negedge mclk);
    chk("still blocked", agu_ok_q[nx(i)], 1'b0);
    @(negedge mclk);
    chk("released entry", agu_ok_q[nx(i)], 1'b1);
    addr(1, nx(i), 32'h00003000);
    chk("dependant scanned", probe_a_q[0].idx, nx(i));
    $display("test dep done");
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    t_load();
    t_order();
    t_full();
    t_pair();
    t_dep();
    summarize();
  end
endmodule
`default_nettype wire

/* verif/mqp_properties.sv */
// mqp_properties: port checker for the memory operation queue pipe
// assumes one clock mclk; bound to every design instance
`timescale 1ns/10ps
`default_nettype none
module mqp_properties (
  // clock and reset
  input wire logic                           mclk,
  input wire logic                           reset_n,
  input wire logic                           clk_en,
  // dispatch and address generators
  input wire logic                           disp_valid,
  input wire mqp_pkg::mqp_macro_t            disp_op,
  input wire logic                           disp_ready_q,
  input wire logic [mqp_pkg::IDXW-1:0]       disp_idx_q,
  input wire mqp_pkg::mqp_agu_t [1:0]        agu_in,
  input wire logic [mqp_pkg::QDEPTH-1:0]     agu_ok_q,
  // probe pipeline and results
  input wire mqp_pkg::mqp_probe_t [1:0]      probe_a_q,
  input wire mqp_pkg::mqp_probe_t [1:0]      probe_b_q,
  input wire logic [1:0][mqp_pkg::DATAW-1:0] dc_rdata,
  input wire mqp_pkg::mqp_result_t [1:0]     result_q,
  input wire logic [1:0]                     ieu_start_q
);
  wire logic [4:0] step = (disp_op.has_load & disp_op.has_store) ? 5'h02 : 5'h01;
  wire logic [3:0] nxt = 4'((disp_idx_q + step) % 5'h0C);
  wire logic [3:0] slot1_idx = (probe_a_q[0].idx == mqp_pkg::IDX_LAST) ?
                               mqp_pkg::IDX_ZERO : probe_a_q[0].idx + mqp_pkg::IDX_ONE;
  wire logic b0_load = probe_b_q[0].valid && probe_b_q[0].kind == mqp_pkg::MQP_LOAD;
  wire logic b0_exec = b0_load && probe_b_q[0].load_exec;
  wire logic two_st = probe_a_q[0].kind == mqp_pkg::MQP_STORE &&
                      probe_a_q[1].kind == mqp_pkg::MQP_STORE;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_stage_a_to_b: assert property (clk_en && probe_a_q[0].valid |=>
    probe_b_q[0] == $past(probe_a_q[0])) else $error("stage b lost slot");
  a_load_result: assert property (clk_en && b0_load |=> result_q[0].valid &&
    result_q[0].data == $past(dc_rdata[0])) else $error("load data wrong");
  a_exec_start: assert property (clk_en |=>
    ieu_start_q[0] == $past(b0_exec)) else $error("execute start wrong");
  a_slot_order: assert property (probe_a_q[1].valid |->
    probe_a_q[0].valid && probe_a_q[1].idx == slot1_idx) else $error("slot order");
  a_pair_legal: assert property (probe_a_q[1].valid && two_st |->
    probe_a_q[0].width == mqp_pkg::MQP_W32 && probe_a_q[1].width == mqp_pkg::MQP_W32)
    else $error("illegal pair");
  a_idx_step: assert property (clk_en && disp_valid && disp_ready_q |=>
    disp_idx_q == $past(nxt)) else $error("dispatch index step");
  a_hold_refused: assert property (clk_en && !(disp_valid && disp_ready_q) |=>
    $stable(disp_idx_q)) else $error("index moved without dispatch");
  a_addr_taken: assert property (clk_en && agu_in[0].valid &&
    agu_ok_q[agu_in[0].idx] |=> !agu_ok_q[$past(agu_in[0].idx)])
    else $error("address not taken");
  c_pair: cover property (probe_a_q[0].valid && probe_a_q[1].valid);
  c_exec: cover property (ieu_start_q[0]);
  c_stall: cover property (!disp_ready_q);
endmodule
bind mqp_memop_queue_pipe mqp_properties i_props (.mclk, .reset_n, .clk_en,
  .disp_valid, .disp_op, .disp_ready_q, .disp_idx_q, .agu_in, .agu_ok_q,
  .probe_a_q, .probe_b_q, .dc_rdata, .result_q, .ieu_start_q);
`default_nettype wire
